// *** hdl/jmpc_map.svh ***
// jmpc_map.svh: register offsets, reset values and timing counts of the panel control block
// assumes: included by the top module, the checker and the test bench, 50 MHz system clock
`ifndef JMPC_MAP_SVH
`define JMPC_MAP_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define JMPC_OFF_KEYS      12'h000
`define JMPC_OFF_STATUS    12'h004
`define JMPC_OFF_ANALOG    12'h008
`define JMPC_OFF_THR_PCT   12'h00C
`define JMPC_OFF_THR_NS    12'h010
`define JMPC_OFF_MEAS      12'h014
`define JMPC_OFF_OUTPUTS   12'h018
`define JMPC_OFF_VERSION   12'h01C
// ------------------------------------------------------------
// key bit positions in the keys register
// ------------------------------------------------------------
`define JMPC_KEY_MEDIA     0
`define JMPC_KEY_EQ        1
`define JMPC_KEY_CLKREC    2
`define JMPC_KEY_TCONST    3
`define JMPC_KEY_SLICE     4
`define JMPC_KEY_DELAY     5
`define JMPC_KEY_SCALE     6
`define JMPC_KEY_INHIBIT   7
`define JMPC_KEY_JUDGE     8
`define JMPC_KEY_SHIFT     9
`define JMPC_NUM_KEYS      10
// ------------------------------------------------------------
// status bit positions
// ------------------------------------------------------------
`define JMPC_ST_NOSIG      0
`define JMPC_ST_CLKBAD     1
// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define JMPC_THR_RST       16'h0100
`define JMPC_OFFSET_MAX    8'h0A
`define JMPC_MANUAL_MIN    8'h0A
`define JMPC_MANUAL_MAX    8'h5A
`define JMPC_PHASE_TARGET  9'h0B4
`define JMPC_VERSION_VAL   32'h0001_0000
// ------------------------------------------------------------
// timing: fail lamp blink half period
// ------------------------------------------------------------
`define JMPC_CLK_HZ        50000000
`define JMPC_BLINK_MS      250
`define JMPC_BLINK_CYC     ((`JMPC_CLK_HZ / 1000) * `JMPC_BLINK_MS)
`endif

// *** hdl/jmpc_pkg.sv ***
// jmpc_pkg.sv: types shared by the panel control block
// assumes: constants come from jmpc_map.svh
package jmpc_pkg;
  typedef enum logic [1:0] {MEDIA_DVD = 2'b00, MEDIA_CD = 2'b01} jmpc_media_type;
  typedef enum logic [1:0] {SLICE_AUTO = 2'b00, SLICE_OFFSET = 2'b01, SLICE_MANUAL = 2'b11} jmpc_slice_type;
  typedef enum logic [1:0] {METER_MEAS = 2'b00, METER_SLICE = 2'b01, METER_JUDGE = 2'b11,
                            METER_VERSION = 2'b10} jmpc_meter_type;
  typedef struct packed {
    jmpc_media_type media;
    logic           equalizer_enable;
    logic           clk_recovery;
    logic [1:0]     tconst;
    jmpc_slice_type slice_mode;
    logic           delay_manual;
    logic           unit_ns;
    logic           scale_pct;
    logic [1:0]     scale_ns;
    logic           inhibit_on;
    logic           inhibit_inv;
  } jmpc_settings_type;
endpackage : jmpc_pkg

// *** hdl/jmpc_top.sv ***
// jmpc_top.sv: front panel control of a jitter meter, keys, settings, meter source and judge lamps
// assumes: APB master on sys_clk, keys arrive as levels in a register written by panel firmware
//
// Overview of operation
// - media key toggles media between CD and DVD; indicator shows it
// - shift plus media key initializes all settings
// - equalizer key toggles equalizer; lamp lit while on
// - equalizer cannot be enabled while media is CD
// - clock recovery key toggles loop; clock taken from RF when on
// - time constant key cycles 0.03, 0.1, 0.3, 1 s
// - shift plus time constant key shows firmware version
// - slice key cycles auto, offset, manual; indicator shows mode
// - shift plus slice key held shows slice level on meter
// - offset mode adds user offset clamped to plus or minus 10 percent
// - manual mode uses user level clamped to 10 to 90 percent
// - delay key toggles delay mode auto and manual
// - auto delay servos average phase toward 180 degrees
// - delay control sets delay only in manual mode
// - percent unit: scale key toggles 10 and 20 percent
// - ns unit: scale key cycles 1.5, 5, 15, 50 ns
// - shift plus scale key toggles percent and ns unit
// - inhibit key toggles inhibit; with shift inverts polarity
// - judge key held shows threshold on meter
// - pass lamp when below threshold, fail lamp when above
// - fail lamp blinks on no signal or clock out of range
// - separate threshold kept per unit
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "jmpc_map.svh"
module jmpc_top #(
  parameter int BLINK_CYC = `JMPC_BLINK_CYC
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  // settings and indicators
  output jmpc_pkg::jmpc_settings_type     settings,
  output jmpc_pkg::jmpc_meter_type        meter_src,
  output logic [7:0]                      slice_level,
  output logic [8:0]                      clock_delay,
  output logic                            pass_led,
  output logic                            fail_led
);
  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire        wr_en    = psel & penable & pwrite;
  wire        rd_en    = psel & penable & ~pwrite;
  wire        sel_keys = paddr == `JMPC_OFF_KEYS;
  wire        sel_st   = paddr == `JMPC_OFF_STATUS;
  wire        sel_an   = paddr == `JMPC_OFF_ANALOG;
  wire        sel_tp   = paddr == `JMPC_OFF_THR_PCT;
  wire        sel_tn   = paddr == `JMPC_OFF_THR_NS;
  wire        sel_ms   = paddr == `JMPC_OFF_MEAS;
  wire        sel_out  = paddr == `JMPC_OFF_OUTPUTS;
  wire        sel_ver  = paddr == `JMPC_OFF_VERSION;
  wire        mapped   = sel_keys | sel_st | sel_an | sel_tp | sel_tn | sel_ms | sel_out | sel_ver;

  logic [`JMPC_NUM_KEYS-1:0] keys_reg;
  logic [`JMPC_NUM_KEYS-1:0] keys_prev_reg;
  logic [1:0]                status_reg;
  logic [7:0]                offset_knob_reg;
  logic [7:0]                level_knob_reg;
  logic [8:0]                delay_knob_reg;
  logic [15:0]               thr_pct_reg;
  logic [15:0]               thr_ns_reg;
  logic [15:0]               meas_reg;
  logic [8:0]                phase_reg;
  logic [7:0]                auto_level_reg;
  jmpc_pkg::jmpc_settings_type set_reg;
  jmpc_pkg::jmpc_meter_type    meter_reg;
  logic [7:0]                slice_reg;
  logic [8:0]                delay_reg;
  logic                      pass_reg;
  logic                      fail_reg;
  logic                      blink_reg;
  logic [31:0]               blink_cnt_reg;
  logic [31:0]               prdata_reg;
  logic                      pslverr_reg;

  // ------------------------------------------------------------
  // key edges, shift qualifies the press
  // ------------------------------------------------------------
  wire [`JMPC_NUM_KEYS-1:0] press = keys_reg & ~keys_prev_reg;
  wire shift   = keys_reg[`JMPC_KEY_SHIFT];
  wire p_media = press[`JMPC_KEY_MEDIA];
  wire p_eq    = press[`JMPC_KEY_EQ] & ~shift;
  wire p_clk   = press[`JMPC_KEY_CLKREC] & ~shift;
  wire p_tc    = press[`JMPC_KEY_TCONST] & ~shift;
  wire p_slice = press[`JMPC_KEY_SLICE] & ~shift;
  wire p_delay = press[`JMPC_KEY_DELAY] & ~shift;
  wire p_scale = press[`JMPC_KEY_SCALE] & ~shift;
  wire p_unit  = press[`JMPC_KEY_SCALE] & shift;
  wire p_inh   = press[`JMPC_KEY_INHIBIT] & ~shift;
  wire p_pol   = press[`JMPC_KEY_INHIBIT] & shift;
  wire do_init = p_media & shift;
  wire do_media = p_media & ~shift;
  wire p_ver   = press[`JMPC_KEY_TCONST] & shift;

  // ------------------------------------------------------------
  // next settings
  // ------------------------------------------------------------
  jmpc_pkg::jmpc_settings_type set_next;
  jmpc_pkg::jmpc_settings_type set_init;
  always_comb
  begin
    set_init = '0;
    set_init.media = jmpc_pkg::MEDIA_DVD;
    set_init.slice_mode = jmpc_pkg::SLICE_AUTO;
    set_next = set_reg;
    if (do_media)
    begin
      set_next.media = (set_reg.media == jmpc_pkg::MEDIA_CD) ? jmpc_pkg::MEDIA_DVD
                                                            : jmpc_pkg::MEDIA_CD;
    end
    if (p_eq)
    begin
      set_next.equalizer_enable = ~set_reg.equalizer_enable;
    end
    if (p_clk)
    begin
      set_next.clk_recovery = ~set_reg.clk_recovery;
    end
    if (p_tc)
    begin
      set_next.tconst = set_reg.tconst + 2'h1;
    end
    if (p_slice)
    begin
      case (set_reg.slice_mode)
        jmpc_pkg::SLICE_AUTO:   set_next.slice_mode = jmpc_pkg::SLICE_OFFSET;
        jmpc_pkg::SLICE_OFFSET: set_next.slice_mode = jmpc_pkg::SLICE_MANUAL;
        default:                set_next.slice_mode = jmpc_pkg::SLICE_AUTO;
      endcase
    end
    if (p_delay)
    begin
      set_next.delay_manual = ~set_reg.delay_manual;
    end
    if (p_scale && !set_reg.unit_ns)
    begin
      set_next.scale_pct = ~set_reg.scale_pct;
    end
    if (p_scale && set_reg.unit_ns)
    begin
      set_next.scale_ns = set_reg.scale_ns + 2'h1;
    end
    if (p_unit)
    begin
      set_next.unit_ns = ~set_reg.unit_ns;
    end
    if (p_inh)
    begin
      set_next.inhibit_on = ~set_reg.inhibit_on;
    end
    if (p_pol)
    begin
      set_next.inhibit_inv = ~set_reg.inhibit_inv;
    end
    // eq refused with CD, also dropped when media switches to CD
    if (set_next.media == jmpc_pkg::MEDIA_CD)
    begin
      set_next.equalizer_enable = 1'b0;
    end
    if (do_init)
    begin
      set_next = set_init;
    end
  end

  // ------------------------------------------------------------
  // meter source: held keys override, version latched until next press
  // ------------------------------------------------------------
  wire any_press = |press[`JMPC_KEY_SHIFT-1:0];
  wire slice_show = keys_reg[`JMPC_KEY_SLICE] & shift;
  wire judge_show = keys_reg[`JMPC_KEY_JUDGE];
  jmpc_pkg::jmpc_meter_type meter_next;
  always_comb
  begin
    if (judge_show)
      meter_next = jmpc_pkg::METER_JUDGE;
    else if (slice_show)
      meter_next = jmpc_pkg::METER_SLICE;
    else if (p_ver)
      meter_next = jmpc_pkg::METER_VERSION;
    else if (any_press || meter_reg != jmpc_pkg::METER_VERSION)
      meter_next = jmpc_pkg::METER_MEAS;
    else
      meter_next = meter_reg;
  end

  // ------------------------------------------------------------
  // slice level and delay
  // ------------------------------------------------------------
  wire signed [8:0] off_s   = $signed({offset_knob_reg[7], offset_knob_reg});
  wire signed [8:0] off_max = $signed({1'b0, `JMPC_OFFSET_MAX});
  wire signed [8:0] off_c   = (off_s > off_max) ? off_max : (off_s < -off_max) ? -off_max : off_s;
  wire signed [9:0] sum_off = $signed({2'b00, auto_level_reg}) + 10'(off_c);
  wire [7:0] off_level = (sum_off < 0) ? 8'h00 : (sum_off > 10'sd255) ? 8'hFF : sum_off[7:0];
  wire [7:0] man_level = (level_knob_reg < `JMPC_MANUAL_MIN) ? `JMPC_MANUAL_MIN :
                         (level_knob_reg > `JMPC_MANUAL_MAX) ? `JMPC_MANUAL_MAX : level_knob_reg;
  wire [7:0] slice_next = (set_reg.slice_mode == jmpc_pkg::SLICE_MANUAL) ? man_level :
                          (set_reg.slice_mode == jmpc_pkg::SLICE_OFFSET) ? off_level : auto_level_reg;
  // auto servo steps one unit a cycle; slow but never overshoots
  wire [8:0] auto_delay = (phase_reg < `JMPC_PHASE_TARGET && delay_reg != 9'h1FF) ? delay_reg + 9'h001 :
                          (phase_reg > `JMPC_PHASE_TARGET && delay_reg != 9'h000) ? delay_reg - 9'h001 :
                          delay_reg;
  wire [8:0] delay_next = set_reg.delay_manual ? delay_knob_reg : auto_delay;

  // ------------------------------------------------------------
  // judgement
  // ------------------------------------------------------------
  wire [15:0] thr     = set_reg.unit_ns ? thr_ns_reg : thr_pct_reg;
  wire        bad_sig = |status_reg;
  wire        blink_t = blink_cnt_reg == 32'(BLINK_CYC - 1);
  wire        pass_next = ~bad_sig & (meas_reg < thr);
  wire        fail_next = bad_sig ? blink_reg : (meas_reg > thr);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [31:0] rd_mux =
    sel_keys ? {22'h00_0000, keys_reg} :
    sel_st   ? {30'h0000_0000, status_reg} :
    sel_an   ? {7'h00, delay_knob_reg, level_knob_reg, offset_knob_reg} :
    sel_tp   ? {16'h0000, thr_pct_reg} :
    sel_tn   ? {16'h0000, thr_ns_reg} :
    sel_ms   ? {7'h00, phase_reg, meas_reg} :
    sel_out  ? {3'h0, fail_reg, pass_reg, meter_reg, slice_reg, 2'h0, set_reg} :
    sel_ver  ? `JMPC_VERSION_VAL : 32'h0000_0000;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      keys_reg        <= '0;
      offset_knob_reg <= 8'h00;
      level_knob_reg  <= 8'h32;
      delay_knob_reg  <= 9'h000;
      thr_pct_reg     <= `JMPC_THR_RST;
      thr_ns_reg      <= `JMPC_THR_RST;
      status_reg      <= 2'h0;
      meas_reg        <= 16'h0000;
      phase_reg       <= 9'h000;
      auto_level_reg  <= 8'h32;
    end
    else if (wr_en)
    begin
      if (sel_keys) keys_reg <= pwdata[`JMPC_NUM_KEYS-1:0];
      if (sel_st)   status_reg <= pwdata[1:0];
      if (sel_an)
      begin
        offset_knob_reg <= pwdata[7:0];
        level_knob_reg  <= pwdata[15:8];
        delay_knob_reg  <= pwdata[24:16];
      end
      if (sel_tp) thr_pct_reg <= pwdata[15:0];
      if (sel_tn) thr_ns_reg  <= pwdata[15:0];
      if (sel_ms)
      begin
        meas_reg  <= pwdata[15:0];
        phase_reg <= pwdata[24:16];
        auto_level_reg <= {pwdata[31:25], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      keys_prev_reg <= '0;
      set_reg       <= '0;
      meter_reg     <= jmpc_pkg::METER_MEAS;
      slice_reg     <= 8'h00;
      delay_reg     <= 9'h000;
      pass_reg      <= 1'b0;
      fail_reg      <= 1'b0;
      blink_reg     <= 1'b0;
      blink_cnt_reg <= 32'h0000_0000;
      prdata_reg    <= 32'h0000_0000;
      pslverr_reg   <= 1'b0;
    end
    else
    begin
      keys_prev_reg <= keys_reg;
      set_reg       <= set_next;
      meter_reg     <= meter_next;
      slice_reg     <= slice_next;
      delay_reg     <= delay_next;
      pass_reg      <= pass_next;
      fail_reg      <= fail_next;
      blink_cnt_reg <= blink_t ? 32'h0000_0000 : blink_cnt_reg + 32'h0000_0001;
      blink_reg     <= blink_t ? ~blink_reg : blink_reg;
      prdata_reg    <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_reg;
      pslverr_reg   <= psel & ~penable & ~mapped;
    end
  end

  // ------------------------------------------------------------
  // outputs; zero wait states, read data staged in setup cycle
  // ------------------------------------------------------------
  assign pready      = 1'b1;
  assign prdata      = prdata_reg;
  assign pslverr     = pslverr_reg;
  assign settings    = set_reg;
  assign meter_src   = meter_reg;
  assign slice_level = slice_reg;
  assign clock_delay = delay_reg;
  assign pass_led    = pass_reg;
  assign fail_led    = fail_reg;
  wire unused_rd = rd_en;
endmodule : jmpc_top

// *** sim/jmpc_assertions.sv ***
// jmpc_assertions.sv: checker bound to the panel control top
// assumes: keys arrive as levels over apb, one clock domain
`timescale 1ns/1ps
`include "jmpc_map.svh"
module jmpc_checker (
  // clock and reset
  input wire logic                        sys_clk,
  input wire logic                        rst,
  // apb
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [11:0]                 paddr,
  input wire logic [31:0]                 pwdata,
  // panel outputs
  input wire jmpc_pkg::jmpc_settings_type settings,
  input wire jmpc_pkg::jmpc_meter_type    meter_src,
  input wire logic                        pass_led,
  input wire logic                        fail_led
);
  // ----------
  // key press tracking
  // ----------
  logic [9:0] keys_q;
  wire        kw = psel && penable && pwrite && paddr == `JMPC_OFF_KEYS;
  wire  [9:0] pr = kw ? pwdata[9:0] & ~keys_q : 10'h000;
  wire        sh = pwdata[`JMPC_KEY_SHIFT];
  wire  [1:0] sl = settings.slice_mode;
  // next slice mode precomputed, sampled three edges back
  wire  [1:0] sl_nx = sl == 2'h0 ? 2'h1 : (sl == 2'h1 ? 2'h3 : 2'h0);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      keys_q <= 10'h000;
    else if (kw)
      keys_q <= pwdata[9:0];
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  media_toggle_a : assert property (pr[0] && !sh |-> ##3 settings.media != $past(settings.media, 3))
    else $error("media did not toggle");
  init_clear_a : assert property (pr[0] && sh |-> ##3 settings == 15'h0000)
    else $error("init left settings");
  eq_cd_a : assert property (settings.media == jmpc_pkg::MEDIA_CD |-> !settings.equalizer_enable)
    else $error("equalizer on with cd");
  tconst_step_a : assert property (pr[3] && !sh |-> ##3 settings.tconst == $past(settings.tconst, 3) + 2'h1)
    else $error("time constant step");
  version_show_a : assert property (pr[3] && sh |-> ##3 meter_src == jmpc_pkg::METER_VERSION)
    else $error("version not shown");
  slice_cycle_a : assert property (pr[4] && !sh |-> ##3 settings.slice_mode == $past(sl_nx, 3))
    else $error("slice mode order");
  slice_show_a : assert property (pr[4] && sh && !pwdata[8] |-> ##[1:3] meter_src == jmpc_pkg::METER_SLICE)
    else $error("slice level not shown");
  ns_step_a : assert property (pr[6] && !sh && settings.unit_ns |-> ##3 settings.scale_ns == $past(settings.scale_ns, 3) + 2'h1)
    else $error("ns scale step");
  unit_swap_a : assert property (pr[6] && sh |-> ##3 settings.unit_ns != $past(settings.unit_ns, 3))
    else $error("unit not switched");
  judge_show_a : assert property (kw && pwdata[8] |-> ##[1:3] meter_src == jmpc_pkg::METER_JUDGE)
    else $error("threshold not shown");
  lamp_excl_a : assert property (!(pass_led && fail_led))
    else $error("pass and fail both lit");
endmodule : jmpc_checker
bind jmpc_top jmpc_checker i_jmpc_checker (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .settings(settings), .meter_src(meter_src),
  .pass_led(pass_led), .fail_led(fail_led));

// *** sim/jmpc_panel_model.sv ***
// jmpc_panel_model.sv: panel firmware model, turns key and knob actions into apb transfers
// assumes: apb slave on sys_clk, transfer ends when pready is high at an access edge
`timescale 1ns/1ps
module jmpc_panel_model (
  // clock
  input wire logic        sys_clk,
  // apb master
  output logic            psel = 1'b0,
  output logic            penable = 1'b0,
  output logic            pwrite = 1'b0,
  output logic [11:0]     paddr = 12'h000,
  output logic [31:0]     pwdata = 32'h0000_0000,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  // waits for pready as long as it takes; only the bench watchdog ends a stuck transfer
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : jmpc_panel_model

// *** sim/test_jitter_meter_panel_control.sv ***
// test_jitter_meter_panel_control.sv: self-checking bench of the panel control top
// assumes: panel model drives apb, blink half period cut to 4 cycles
`timescale 1ns/1ps
`include "jmpc_map.svh"
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module test_jitter_meter_panel_control;
  logic                        sys_clk = 1'b0;
  logic                        rst = 1'b1;
  logic                        psel, penable, pwrite, pready, pslverr, pass_led, fail_led, err, last;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata, rd;
  logic [7:0]                  slice_level;
  logic [8:0]                  clock_delay;
  jmpc_pkg::jmpc_settings_type settings;
  jmpc_pkg::jmpc_meter_type    meter_src;
  jmpc_pkg::jmpc_slice_type    sl_mode [3] = '{jmpc_pkg::SLICE_OFFSET, jmpc_pkg::SLICE_MANUAL, jmpc_pkg::SLICE_AUTO};
  logic [7:0]                  sl_lvl [3] = '{8'h3C, 8'h5A, 8'h32};
  int                          n_errors = 0;
  int                          comparisons = 0;
  int                          flips;
  always #10 sys_clk = ~sys_clk;
  jmpc_top #(.BLINK_CYC(4)) i_jmpc_top (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .settings(settings), .meter_src(meter_src), .slice_level(slice_level), .clock_delay(clock_delay),
    .pass_led(pass_led), .fail_led(fail_led));
  jmpc_panel_model i_jmpc_panel_model (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // ----------
  // access tasks
  // ----------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_jmpc_panel_model.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    i_jmpc_panel_model.xfer(1'b0, a, 32'h0000_0000, rd, err);
    `CHK(rd, x)
  endtask : rdc
  task automatic settle;
    repeat (3) @(posedge sys_clk);
  endtask : settle
  // key released before the next press, else no edge is seen
  task automatic press(input int k, input logic s);
    wr(`JMPC_OFF_KEYS, {22'h00_0000, s, 9'h000} | (32'h0000_0001 << k));
    wr(`JMPC_OFF_KEYS, 32'h0000_0000);
    settle();
  endtask : press
  task automatic results;
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial
  begin
    #400000;
    n_errors++;
    results();
  end
  // ----------
  // tests
  // ----------
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK(settings, 15'h0000)
    rdc(`JMPC_OFF_VERSION, `JMPC_VERSION_VAL);
    rdc(`JMPC_OFF_THR_PCT, {16'h0000, `JMPC_THR_RST});
    rdc(12'h020, 32'h0000_0000);
    `CHK(err, 1'b1)
    press(`JMPC_KEY_MEDIA, 1'b0);
    `CHK(settings.media, jmpc_pkg::MEDIA_CD)
    press(`JMPC_KEY_EQ, 1'b0);
    `CHK(settings.equalizer_enable, 1'b0)
    press(`JMPC_KEY_MEDIA, 1'b0);
    `CHK(settings.media, jmpc_pkg::MEDIA_DVD)
    press(`JMPC_KEY_EQ, 1'b0);
    `CHK(settings.equalizer_enable, 1'b1)
    press(`JMPC_KEY_MEDIA, 1'b0);
    `CHK(settings.equalizer_enable, 1'b0)
    press(`JMPC_KEY_CLKREC, 1'b0);
    `CHK(settings.clk_recovery, 1'b1)
    for (int i = 1; i <= 4; i++)
    begin
      press(`JMPC_KEY_TCONST, 1'b0);
      `CHK(settings.tconst, 2'(i))
    end
    press(`JMPC_KEY_TCONST, 1'b1);
    `CHK(meter_src, jmpc_pkg::METER_VERSION)
    `CHK(settings.tconst, 2'h0)
    wr(`JMPC_OFF_KEYS, 32'h0000_0210);
    settle();
    `CHK(meter_src, jmpc_pkg::METER_SLICE)
    `CHK(settings.slice_mode, jmpc_pkg::SLICE_AUTO)
    wr(`JMPC_OFF_KEYS, 32'h0000_0100);
    settle();
    `CHK(meter_src, jmpc_pkg::METER_JUDGE)
    wr(`JMPC_OFF_KEYS, 32'h0000_0000);
    settle();
    `CHK(meter_src, jmpc_pkg::METER_MEAS)
    // auto level 50, offset +20 clamps to +10, manual 96 clamps to 90
    wr(`JMPC_OFF_MEAS, 32'h32B4_0050);
    wr(`JMPC_OFF_ANALOG, 32'h0055_6014);
    settle();
    `CHK(slice_level, 8'h32)
    for (int i = 0; i < 3; i++)
    begin
      press(`JMPC_KEY_SLICE, 1'b0);
      `CHK(settings.slice_mode, sl_mode[i])
      `CHK(slice_level, sl_lvl[i])
    end
    `CHK({pass_led, fail_led}, 2'b10)
    wr(`JMPC_OFF_MEAS, 32'h32B4_0200);
    settle();
    `CHK({pass_led, fail_led}, 2'b01)
    for (int b = 1; b <= 2; b++)
    begin
      wr(`JMPC_OFF_STATUS, b);
      settle();
      flips = 0;
      for (int i = 0; i < 16; i++)
      begin
        last = fail_led;
        @(posedge sys_clk);
        flips += int'(fail_led !== last);
      end
      `CHK(flips >= 3, 1'b1)
    end
    wr(`JMPC_OFF_STATUS, 32'h0000_0000);
    press(`JMPC_KEY_DELAY, 1'b0);
    `CHK(settings.delay_manual, 1'b1)
    `CHK(clock_delay, 9'h055)
    press(`JMPC_KEY_DELAY, 1'b0);
    `CHK(settings.delay_manual, 1'b0)
    `CHK(clock_delay, 9'h055)
    // phase below 180 for 11 edges: servo climbs one step per edge
    wr(`JMPC_OFF_MEAS, 32'h32B0_0200);
    repeat (8) @(posedge sys_clk);
    wr(`JMPC_OFF_MEAS, 32'h32B4_0200);
    settle();
    `CHK(clock_delay, 9'h060)
    press(`JMPC_KEY_SCALE, 1'b0);
    `CHK(settings.scale_pct, 1'b1)
    press(`JMPC_KEY_SCALE, 1'b0);
    `CHK(settings.scale_pct, 1'b0)
    press(`JMPC_KEY_SCALE, 1'b1);
    `CHK({settings.unit_ns, settings.scale_pct}, 2'b10)
    for (int i = 1; i <= 4; i++)
    begin
      press(`JMPC_KEY_SCALE, 1'b0);
      `CHK(settings.scale_ns, 2'(i))
    end
    wr(`JMPC_OFF_THR_PCT, 32'h0000_0030);
    wr(`JMPC_OFF_THR_NS, 32'h0000_0400);
    settle();
    `CHK({pass_led, fail_led}, 2'b10)
    press(`JMPC_KEY_SCALE, 1'b1);
    `CHK({pass_led, fail_led}, 2'b01)
    rdc(`JMPC_OFF_THR_NS, 32'h0000_0400);
    press(`JMPC_KEY_INHIBIT, 1'b0);
    `CHK(settings.inhibit_on, 1'b1)
    press(`JMPC_KEY_INHIBIT, 1'b1);
    `CHK({settings.inhibit_on, settings.inhibit_inv}, 2'b11)
    press(`JMPC_KEY_MEDIA, 1'b1);
    `CHK(settings, 15'h0000)
    rdc(`JMPC_OFF_OUTPUTS, 32'h1064_0000);
    results();
  end
endmodule : test_jitter_meter_panel_control
